// ### hdl/tcz_pkg.sv
package tcz_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] TCZ_IDX_CTRL = 8'h64;
  localparam logic [7:0] TCZ_IDX_IO = 8'h65;
  localparam logic [7:0] TCZ_IDX_IER = 8'h66;
  localparam logic [7:0] TCZ_IDX_STAT = 8'h67;
  localparam logic [7:0] TCZ_IDX_COUNT = 8'h68;
  localparam logic [7:0] TCZ_IDX_GRA = 8'h69;
  localparam logic [7:0] TCZ_IDX_GRB = 8'h6A;

  // Reserved bits, read back as ones
  localparam logic [7:0] TCZ_CTRL_RSVD = 8'h80;
  localparam logic [7:0] TCZ_IO_RSVD = 8'h88;
  localparam logic [7:0] TCZ_IER_RSVD = 8'hF8;
  localparam logic [7:0] TCZ_STAT_RSVD = 8'hF8;

  // Reset values of the writable state
  localparam logic [7:0] TCZ_CTRL_RST = 8'h00;
  localparam logic [7:0] TCZ_IO_RST = 8'h00;
  localparam logic [2:0] TCZ_IER_RST = 3'h0;
  localparam logic [2:0] TCZ_STAT_RST = 3'h0;
  localparam logic [15:0] TCZ_COUNT_RST = 16'h0000;
  localparam logic [15:0] TCZ_GR_RST = 16'hFFFF;

  // Flag and enable bit positions
  localparam int TCZ_BIT_A = 0;
  localparam int TCZ_BIT_B = 1;
  localparam int TCZ_BIT_OVF = 2;

  // Clear source codes
  localparam logic [1:0] TCZ_CLR_NONE = 2'h0;
  localparam logic [1:0] TCZ_CLR_A = 2'h1;
  localparam logic [1:0] TCZ_CLR_B = 2'h2;
  localparam logic [1:0] TCZ_CLR_SYNC = 2'h3;

  // Low two bits of an I/O field
  localparam logic [1:0] TCZ_OUT_KEEP = 2'h0;
  localparam logic [1:0] TCZ_OUT_ZERO = 2'h1;
  localparam logic [1:0] TCZ_OUT_ONE = 2'h2;
  localparam logic [1:0] TCZ_OUT_TOGGLE = 2'h3;
  localparam logic [1:0] TCZ_CAP_RISE = 2'h0;
  localparam logic [1:0] TCZ_CAP_FALL = 2'h1;
  localparam logic [1:0] TCZ_CAP_BOTH = 2'h2;

  typedef struct packed {
    logic rsvd;
    logic [1:0] clear_source;
    logic [1:0] edge_select;
    logic [2:0] clock_select;
  } tcz_ctrl_t;

  typedef struct packed {
    logic rsvd_hi;
    logic [2:0] reg_b_io;
    logic rsvd_lo;
    logic [2:0] reg_a_io;
  } tcz_io_t;

endpackage

// ### hdl/tcz_timer_channel_zero.sv
`timescale 1ns/1ps
module tcz_timer_channel_zero #(
  parameter int COUNT_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_clock_pin_a,
  input wire logic ext_clock_pin_b,
  input wire logic ext_clock_pin_c,
  input wire logic ext_clock_pin_d,
  input wire logic pin_a_in,
  input wire logic pin_b_in,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe,
  input wire logic sync_clear_in,
  output logic sync_clear_out,
  output logic reg_a_irq,
  output logic reg_b_irq,
  output logic overflow_irq,
  output logic irq
);

  localparam int NPIN = 6;

  // Pin synchronisers and edge detection
  logic [NPIN-1:0] pins_raw;
  logic [NPIN-1:0] sync1_reg;
  logic [NPIN-1:0] sync2_reg;
  logic [NPIN-1:0] sync3_reg;
  logic [NPIN-1:0] pin_rise;
  logic [NPIN-1:0] pin_fall;

  assign pins_raw = {pin_b_in, pin_a_in, ext_clock_pin_d, ext_clock_pin_c,
                     ext_clock_pin_b, ext_clock_pin_a};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pins_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
        end
      end
      assign pin_rise[gi] = sync2_reg[gi] & ~sync3_reg[gi];
      assign pin_fall[gi] = ~sync2_reg[gi] & sync3_reg[gi];
    end
  endgenerate

  // Architectural state
  tcz_pkg::tcz_ctrl_t ctrl_reg, ctrl_next;
  tcz_pkg::tcz_io_t io_reg, io_next;
  logic [2:0] ier_reg, ier_next;
  logic [2:0] stat_reg, stat_next;
  logic [2:0] armed_reg, armed_next;
  logic [COUNT_W-1:0] count_reg, count_next;
  logic [COUNT_W-1:0] gra_reg, gra_next;
  logic [COUNT_W-1:0] grb_reg, grb_next;
  logic [2:0] presc_reg, presc_next;
  logic pin_a_out_next, pin_b_out_next;
  logic pin_a_oe_next, pin_b_oe_next;
  logic reg_a_irq_next, reg_b_irq_next, overflow_irq_next, irq_next;
  logic sync_clear_out_next;

  // Bus data phase state
  logic dp_write_reg, dp_write_next;
  logic [7:0] dp_idx_reg, dp_idx_next;
  logic [31:0] hrdata_next;

  // Event terms
  logic tick;
  logic ext_edge;
  logic cmp_a, cmp_b, cap_a, cap_b, ev_a, ev_b;
  logic clear_cnt, ovf_ev;
  logic take, rd_take;
  logic [2:0] set_flag, clr_flag;
  logic [7:0] wbyte;
  logic [COUNT_W-1:0] wword;

  function automatic logic cap_hit(input logic [1:0] mode, input logic rise,
                                   input logic fall);
    logic hit;
    hit = 1'b0;
    unique case (mode)
      tcz_pkg::TCZ_CAP_RISE: hit = rise;
      tcz_pkg::TCZ_CAP_FALL: hit = fall;
      tcz_pkg::TCZ_CAP_BOTH: hit = rise | fall;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic pin_after(input logic [1:0] mode, input logic cur);
    logic v;
    v = cur;
    unique case (mode)
      tcz_pkg::TCZ_OUT_KEEP: v = cur;
      tcz_pkg::TCZ_OUT_ZERO: v = 1'b0;
      tcz_pkg::TCZ_OUT_ONE: v = 1'b1;
      tcz_pkg::TCZ_OUT_TOGGLE: v = ~cur;
    endcase
    return v;
  endfunction

  always_comb begin
    wbyte = hwdata[7:0];
    wword = hwdata[COUNT_W-1:0];
    presc_next = presc_reg + 3'h1;

    // Counting source
    if (ctrl_reg.edge_select[1]) begin
      ext_edge = pin_rise[ctrl_reg.clock_select[1:0]] |
                 pin_fall[ctrl_reg.clock_select[1:0]];
    end else if (ctrl_reg.edge_select[0]) begin
      ext_edge = pin_fall[ctrl_reg.clock_select[1:0]];
    end else begin
      ext_edge = pin_rise[ctrl_reg.clock_select[1:0]];
    end
    unique case (ctrl_reg.clock_select)
      3'h0: tick = 1'b1;
      3'h1: tick = presc_reg[0];
      3'h2: tick = &presc_reg[1:0];
      3'h3: tick = &presc_reg;
      default: tick = ext_edge;
    endcase

    // Compare and capture
    cmp_a = ~io_reg.reg_a_io[2] & tick & (count_reg == gra_reg);
    cmp_b = ~io_reg.reg_b_io[2] & tick & (count_reg == grb_reg);
    cap_a = io_reg.reg_a_io[2] &
            cap_hit(io_reg.reg_a_io[1:0], pin_rise[4], pin_fall[4]);
    cap_b = io_reg.reg_b_io[2] &
            cap_hit(io_reg.reg_b_io[1:0], pin_rise[5], pin_fall[5]);
    ev_a = cmp_a | cap_a;
    ev_b = cmp_b | cap_b;

    unique case (ctrl_reg.clear_source)
      tcz_pkg::TCZ_CLR_NONE: clear_cnt = 1'b0;
      tcz_pkg::TCZ_CLR_A: clear_cnt = ev_a;
      tcz_pkg::TCZ_CLR_B: clear_cnt = ev_b;
      tcz_pkg::TCZ_CLR_SYNC: clear_cnt = sync_clear_in;
    endcase
    ovf_ev = tick & ~clear_cnt & (&count_reg);
  end

  // Pin levels and interrupt requests
  always_comb begin
    sync_clear_out_next = clear_cnt & (ctrl_reg.clear_source != tcz_pkg::TCZ_CLR_SYNC);
    pin_a_out_next = cmp_a ? pin_after(io_reg.reg_a_io[1:0], pin_a_out) : pin_a_out;
    pin_b_out_next = cmp_b ? pin_after(io_reg.reg_b_io[1:0], pin_b_out) : pin_b_out;
    pin_a_oe_next = ~io_next.reg_a_io[2] &
                    (io_next.reg_a_io[1:0] != tcz_pkg::TCZ_OUT_KEEP);
    pin_b_oe_next = ~io_next.reg_b_io[2] &
                    (io_next.reg_b_io[1:0] != tcz_pkg::TCZ_OUT_KEEP);
    reg_a_irq_next = stat_next[tcz_pkg::TCZ_BIT_A] & ier_next[tcz_pkg::TCZ_BIT_A];
    reg_b_irq_next = stat_next[tcz_pkg::TCZ_BIT_B] & ier_next[tcz_pkg::TCZ_BIT_B];
    overflow_irq_next = stat_next[tcz_pkg::TCZ_BIT_OVF] & ier_next[tcz_pkg::TCZ_BIT_OVF];
    irq_next = |(stat_next & ier_next);
  end

  // Configuration, counter and captures
  always_comb begin
    // Software writes in the data phase
    ctrl_next = ctrl_reg;
    io_next = io_reg;
    ier_next = ier_reg;
    count_next = count_reg;
    gra_next = gra_reg;
    grb_next = grb_reg;
    clr_flag = 3'h0;
    if (clear_cnt) begin
      count_next = '0;
    end else if (tick) begin
      count_next = count_reg + 1'b1;
    end
    if (cap_a) begin
      gra_next = count_reg;
    end
    if (cap_b) begin
      grb_next = count_reg;
    end
    if (dp_write_reg) begin
      unique case (dp_idx_reg)
        tcz_pkg::TCZ_IDX_CTRL: ctrl_next = wbyte & ~tcz_pkg::TCZ_CTRL_RSVD;
        tcz_pkg::TCZ_IDX_IO: io_next = wbyte & ~tcz_pkg::TCZ_IO_RSVD;
        tcz_pkg::TCZ_IDX_IER: ier_next = wbyte[2:0];
        tcz_pkg::TCZ_IDX_STAT: clr_flag = armed_reg & ~wbyte[2:0];
        tcz_pkg::TCZ_IDX_COUNT: count_next = wword;
        tcz_pkg::TCZ_IDX_GRA: gra_next = wword;
        tcz_pkg::TCZ_IDX_GRB: grb_next = wword;
        default: clr_flag = 3'h0;
      endcase
    end
  end

  // Sticky flags, a new event beats a clear
  always_comb begin
    set_flag = 3'h0;
    set_flag[tcz_pkg::TCZ_BIT_A] = ev_a;
    set_flag[tcz_pkg::TCZ_BIT_B] = ev_b;
    set_flag[tcz_pkg::TCZ_BIT_OVF] = ovf_ev;
    stat_next = set_flag | (stat_reg & ~clr_flag);

    // Read arms the flags it returns, a status write disarms all unless a status read is taken in the same cycle
    armed_next = armed_reg & ~clr_flag;
    if (dp_write_reg && dp_idx_reg == tcz_pkg::TCZ_IDX_STAT) begin
      armed_next = 3'h0;
    end
    if (rd_take && haddr[9:2] == tcz_pkg::TCZ_IDX_STAT) begin
      armed_next = stat_next;
    end
  end

  // Address phase and read data
  always_comb begin
    take = hsel & hready & htrans[1];
    rd_take = take & ~hwrite & (haddr[31:10] == 22'h00_0000);
    dp_write_next = take & hwrite & (haddr[31:10] == 22'h00_0000);
    dp_idx_next = take ? haddr[9:2] : dp_idx_reg;
    hrdata_next = 32'h0000_0000;
    if (rd_take) begin
      unique case (haddr[9:2])
        tcz_pkg::TCZ_IDX_CTRL: hrdata_next[7:0] = ctrl_next | tcz_pkg::TCZ_CTRL_RSVD;
        tcz_pkg::TCZ_IDX_IO: hrdata_next[7:0] = io_next | tcz_pkg::TCZ_IO_RSVD;
        tcz_pkg::TCZ_IDX_IER: hrdata_next[7:0] = {5'h00, ier_next} | tcz_pkg::TCZ_IER_RSVD;
        tcz_pkg::TCZ_IDX_STAT: hrdata_next[7:0] = {5'h00, stat_next} | tcz_pkg::TCZ_STAT_RSVD;
        tcz_pkg::TCZ_IDX_COUNT: hrdata_next[COUNT_W-1:0] = count_next;
        tcz_pkg::TCZ_IDX_GRA: hrdata_next[COUNT_W-1:0] = gra_next;
        tcz_pkg::TCZ_IDX_GRB: hrdata_next[COUNT_W-1:0] = grb_next;
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Configuration and counter registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= tcz_pkg::TCZ_CTRL_RST;
      io_reg <= tcz_pkg::TCZ_IO_RST;
      ier_reg <= tcz_pkg::TCZ_IER_RST;
      count_reg <= tcz_pkg::TCZ_COUNT_RST;
      gra_reg <= tcz_pkg::TCZ_GR_RST;
      grb_reg <= tcz_pkg::TCZ_GR_RST;
      presc_reg <= 3'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      io_reg <= io_next;
      ier_reg <= ier_next;
      count_reg <= count_next;
      gra_reg <= gra_next;
      grb_reg <= grb_next;
      presc_reg <= presc_next;
    end
  end

  // Flag registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_reg <= tcz_pkg::TCZ_STAT_RST;
      armed_reg <= 3'h0;
    end else begin
      stat_reg <= stat_next;
      armed_reg <= armed_next;
    end
  end

  // Pin and interrupt registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_a_out <= 1'b0;
      pin_b_out <= 1'b0;
      pin_a_oe <= 1'b0;
      pin_b_oe <= 1'b0;
      sync_clear_out <= 1'b0;
      reg_a_irq <= 1'b0;
      reg_b_irq <= 1'b0;
      overflow_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      pin_a_out <= pin_a_out_next;
      pin_b_out <= pin_b_out_next;
      pin_a_oe <= pin_a_oe_next;
      pin_b_oe <= pin_b_oe_next;
      sync_clear_out <= sync_clear_out_next;
      reg_a_irq <= reg_a_irq_next;
      reg_b_irq <= reg_b_irq_next;
      overflow_irq <= overflow_irq_next;
      irq <= irq_next;
    end
  end

  // Bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_idx_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dp_write_reg <= dp_write_next;
      dp_idx_reg <= dp_idx_next;
      hrdata <= hrdata_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule

// ### verif/tcz_chk.sv
`timescale 1ns/1ps
module tcz_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic pin_a_oe,
  input wire logic pin_b_oe,
  input wire logic reg_a_irq,
  input wire logic reg_b_irq,
  input wire logic overflow_irq,
  input wire logic irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_t;
  logic rd_t;
  assign wr_t = hsel && hready && htrans[1] && hwrite;
  assign rd_t = hsel && hready && htrans[1] && !hwrite;
  property p_irq_or; irq == (reg_a_irq || reg_b_irq || overflow_irq); endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not OR of sources");
  property p_a_fall; $fell(reg_a_irq) |-> $past(wr_t, 2) || $past(wr_t, 3); endproperty
  a_a_fall: assert property (p_a_fall) else $error("A irq fell without write");
  property p_b_fall; $fell(reg_b_irq) |-> $past(wr_t, 2) || $past(wr_t, 3); endproperty
  a_b_fall: assert property (p_b_fall) else $error("B irq fell without write");
  property p_ov_fall; $fell(overflow_irq) |-> $past(wr_t, 2) || $past(wr_t, 3); endproperty
  a_ov_fall: assert property (p_ov_fall) else $error("ovf irq fell without write");
  property p_oe_a; $changed(pin_a_oe) |-> $past(wr_t, 2) || $past(wr_t, 3); endproperty
  a_oe_a: assert property (p_oe_a) else $error("A enable moved without write");
  property p_oe_b; $changed(pin_b_oe) |-> $past(wr_t, 2) || $past(wr_t, 3); endproperty
  a_oe_b: assert property (p_oe_b) else $error("B enable moved without write");
  property p_rsv_ctl; rd_t && haddr == 32'h0000_0190 |=> hrdata[7]; endproperty
  a_rsv_ctl: assert property (p_rsv_ctl) else $error("ctrl reserved bit low");
  property p_rsv_io; rd_t && haddr == 32'h0000_0194 |=> hrdata[7] && hrdata[3]; endproperty
  a_rsv_io: assert property (p_rsv_io) else $error("io reserved bits low");
  property p_rsv_ier; rd_t && haddr == 32'h0000_0198 |=> hrdata[7:3] == 5'h1F; endproperty
  a_rsv_ier: assert property (p_rsv_ier) else $error("ier reserved bits low");
endmodule

// ### verif/tcz_pin_model.sv
`timescale 1ns/1ps
module tcz_pin_model (
  input wire logic hclk,
  input wire logic pin_a_out,
  input wire logic pin_a_oe,
  input wire logic pin_b_out,
  input wire logic pin_b_oe,
  output logic [3:0] ext_clk,
  output logic pin_a_in,
  output logic pin_b_in
);
  logic [1:0] cap_drv;
  initial begin
    ext_clk = 4'h0;
    cap_drv = 2'h0;
  end
  // Timer wins the wire while it drives
  assign pin_a_in = pin_a_oe ? pin_a_out : cap_drv[0];
  assign pin_b_in = pin_b_oe ? pin_b_out : cap_drv[1];
  // Levels held three clocks, clock still between bursts
  task automatic clk_edges(input int k, input int n);
    repeat (n) begin
      @(posedge hclk);
      ext_clk[k] <= ~ext_clk[k];
      repeat (2) @(posedge hclk);
    end
  endtask
  task automatic cap_edge(input int k);
    @(posedge hclk);
    cap_drv[k] <= ~cap_drv[k];
    repeat (2) @(posedge hclk);
  endtask
endmodule

// ### verif/test_tcz_timer_channel_zero.sv
`timescale 1ns/1ps
module test_tcz_timer_channel_zero;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic sync_clear_in = 1'b0;
  logic [31:0] hrdata, rd_q, d, v;
  logic hreadyout, hresp, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, pin_a_in, pin_b_in;
  logic sync_clear_out, reg_a_irq, reg_b_irq, overflow_irq, irq, pa_q, sel_b;
  logic [3:0] ext_clk;
  logic [1:0] codes [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
  int n_fail = 0;
  int tests_run = 0;
  int n_tog, n_clr;
  always #20 hclk = ~hclk;
  always @(posedge hclk) rd_q <= hrdata;
  // Toggle and clear-pulse monitor, away from the sampling edge
  always @(negedge hclk) begin
    if ((sel_b ? pin_b_out : pin_a_out) !== pa_q) n_tog++;
    pa_q = sel_b ? pin_b_out : pin_a_out;
    if (sync_clear_out === 1'b1) n_clr++;
  end
  tcz_timer_channel_zero u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_clock_pin_a(ext_clk[0]),
    .ext_clock_pin_b(ext_clk[1]), .ext_clock_pin_c(ext_clk[2]), .ext_clock_pin_d(ext_clk[3]),
    .pin_a_in(pin_a_in), .pin_b_in(pin_b_in), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
    .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .sync_clear_in(sync_clear_in),
    .sync_clear_out(sync_clear_out), .reg_a_irq(reg_a_irq), .reg_b_irq(reg_b_irq),
    .overflow_irq(overflow_irq), .irq(irq));
  tcz_pin_model u_pins (.hclk(hclk), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
    .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .ext_clk(ext_clk), .pin_a_in(pin_a_in),
    .pin_b_in(pin_b_in));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    #1 d = rd_q;
  endtask
  task automatic irqs(input logic [3:0] exp);
    chk({28'h0, reg_a_irq, reg_b_irq, overflow_irq, irq}, {28'h0, exp});
  endtask
  initial begin
    #1_000_000;
    n_fail++;
    finish_test();
  end
  initial begin
    sel_b = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, tcz_pkg::TCZ_IDX_CTRL, 0); chk(d, 32'h0000_0080);
    chk({30'h0, hresp, hreadyout}, 32'h0000_0001);
    bus(0, tcz_pkg::TCZ_IDX_IO, 0); chk(d, 32'h0000_0088);
    bus(0, tcz_pkg::TCZ_IDX_IER, 0); chk(d, 32'h0000_00F8);
    bus(0, tcz_pkg::TCZ_IDX_STAT, 0); chk(d, 32'h0000_00F8);
    bus(0, 8'h70, 0); chk(d, 32'h0000_0000);
    bus(1, tcz_pkg::TCZ_IDX_IO, 32'h0000_0077);
    bus(0, tcz_pkg::TCZ_IDX_IO, 0); chk(d, 32'h0000_00FF);
    bus(1, tcz_pkg::TCZ_IDX_IO, 0);
    $display("register test done");
    for (int s = 0; s < 4; s++) begin
      bus(1, tcz_pkg::TCZ_IDX_CTRL, 32'(s));
      bus(0, tcz_pkg::TCZ_IDX_COUNT, 0);
      v = d;
      repeat (61) @(posedge hclk);
      bus(0, tcz_pkg::TCZ_IDX_COUNT, 0); chk((d - v) & 32'h0000_FFFF, 32'(64 >> s));
    end
    for (int s = 4; s < 8; s++) for (int e = 0; e < 4; e++) begin
      bus(1, tcz_pkg::TCZ_IDX_CTRL, 32'(e * 8 + s));
      bus(0, tcz_pkg::TCZ_IDX_COUNT, 0);
      v = d;
      u_pins.clk_edges(s - 4, 8);
      repeat (6) @(posedge hclk);
      bus(0, tcz_pkg::TCZ_IDX_COUNT, 0);
      chk((d - v) & 32'h0000_FFFF, (e > 1) ? 32'h8 : 32'h4);
    end
    $display("clock test done");
    for (int b = 0; b < 2; b++) begin
      sel_b = b[0];
      bus(1, b ? tcz_pkg::TCZ_IDX_GRB : tcz_pkg::TCZ_IDX_GRA, 32'h0000_0009);
      bus(1, tcz_pkg::TCZ_IDX_CTRL, b ? 32'h0000_0040 : 32'h0000_0020);
      bus(1, tcz_pkg::TCZ_IDX_COUNT, 0);
      foreach (codes[i]) begin
        bus(1, tcz_pkg::TCZ_IDX_IO, 32'(codes[i]) << (4 * b));
        repeat (20) @(posedge hclk);
        n_tog = 0;
        n_clr = 0;
        repeat (100) @(posedge hclk);
        chk(32'(n_clr), 32'd10);
        chk(32'(n_tog), (codes[i] == 2'h3) ? 32'd10 : 32'd0);
        chk({31'h0, b ? pin_b_oe : pin_a_oe}, {31'h0, codes[i] != 2'h0});
        if (codes[i] == 2'h1 || codes[i] == 2'h2) begin
          chk({31'h0, b ? pin_b_out : pin_a_out}, {31'h0, codes[i] == 2'h2});
        end
      end
    end
    bus(1, tcz_pkg::TCZ_IDX_CTRL, 32'h0000_0004);
    bus(0, tcz_pkg::TCZ_IDX_STAT, 0); chk(d, 32'h0000_00FB);
    irqs(4'h0);
    bus(1, tcz_pkg::TCZ_IDX_IER, 32'h0000_0003);
    irqs(4'hD);
    bus(1, tcz_pkg::TCZ_IDX_STAT, 32'h0000_00FF);
    bus(1, tcz_pkg::TCZ_IDX_STAT, 0);
    irqs(4'hD);
    bus(0, tcz_pkg::TCZ_IDX_STAT, 0);
    bus(1, tcz_pkg::TCZ_IDX_STAT, 32'h0000_0002);
    irqs(4'h5);
    $display("compare test done");
    for (int b = 0; b < 2; b++) foreach (codes[i]) begin
      bus(1, tcz_pkg::TCZ_IDX_IO, 32'(4 + codes[i]) << (4 * b));
      bus(1, tcz_pkg::TCZ_IDX_COUNT, 32'h0000_1234);
      bus(1, b ? tcz_pkg::TCZ_IDX_GRB : tcz_pkg::TCZ_IDX_GRA, 32'h0000_FFFF);
      u_pins.cap_edge(b);
      bus(0, b ? tcz_pkg::TCZ_IDX_GRB : tcz_pkg::TCZ_IDX_GRA, 0);
      v = (codes[i] == 2'h0 || codes[i] == 2'h2) ? 32'h0000_1234 : 32'h0000_FFFF;
      chk(d, v);
      bus(1, tcz_pkg::TCZ_IDX_COUNT, 32'h0000_5678);
      u_pins.cap_edge(b);
      bus(0, b ? tcz_pkg::TCZ_IDX_GRB : tcz_pkg::TCZ_IDX_GRA, 0);
      chk(d, (codes[i] == 2'h1 || codes[i] == 2'h2) ? 32'h0000_5678 : v);
    end
    bus(0, tcz_pkg::TCZ_IDX_STAT, 0); chk(d, 32'h0000_00FB);
    $display("capture test done");
    bus(1, tcz_pkg::TCZ_IDX_CTRL, 32'h0000_0060);
    @(posedge hclk) sync_clear_in <= 1'b1;
    bus(0, tcz_pkg::TCZ_IDX_COUNT, 0); chk(d, 32'h0000_0000);
    @(posedge hclk) sync_clear_in <= 1'b0;
    bus(1, tcz_pkg::TCZ_IDX_CTRL, 0);
    bus(1, tcz_pkg::TCZ_IDX_COUNT, 32'h0000_FFF0);
    repeat (30) @(posedge hclk);
    irqs(4'hD);
    bus(1, tcz_pkg::TCZ_IDX_IER, 32'h0000_0007);
    irqs(4'hF);
    bus(1, tcz_pkg::TCZ_IDX_IER, 0);
    irqs(4'h0);
    $display("sync and overflow test done");
    finish_test();
  end
endmodule
bind tcz_timer_channel_zero tcz_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .pin_a_oe(pin_a_oe), .pin_b_oe(pin_b_oe), .reg_a_irq(reg_a_irq), .reg_b_irq(reg_b_irq),
  .overflow_irq(overflow_irq), .irq(irq));
